// ---- rtl/sfcc_calib_ctrl.v ----
// Calibration control and synthesizer test override register bank, AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sfcc_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module sfcc_calib_ctrl (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        power_monitor_enable_i,
    input  wire        radio_idle_entry_i,
    input  wire        synth_active_i,
    input  wire        normal_chip_i,
    input  wire        normal_tx_dir_i,
    output wire        modulator_chip_o,
    output wire        synth_tx_dir_o,
    output wire [5:0]  filter_tune_value_o,
    output wire        cal_running_o,
    output wire        irq_o
);
    localparam CW = 10;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [2:0] pin_meta_reg;
    reg [2:0] pin_sync_reg;
    reg       idle_entry_d_reg;

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_reg     <= 3'h0;
            pin_sync_reg     <= 3'h0;
            idle_entry_d_reg <= 1'b0;
        end else begin
            pin_meta_reg     <= {synth_active_i, radio_idle_entry_i,
                                 power_monitor_enable_i};
            pin_sync_reg     <= pin_meta_reg;
            idle_entry_d_reg <= pin_sync_reg[1];
        end
    end

    wire power_mon_en = pin_sync_reg[0];
    wire idle_entry  = pin_sync_reg[1] & ~idle_entry_d_reg;
    wire synth_on    = pin_sync_reg[2];

    //////////////////////////////////////////////////////////////////////////
    // Registers
    reg        ftn_go_reg;
    reg [5:0]  ftn_value_reg;
    reg        ftn_rsvd_reg;
    reg        cf_go_reg;
    reg [6:0]  cf_low_reg;
    reg        dcu_go_reg;
    reg [6:0]  dcu_low_reg;
    reg [7:0]  tst_reg;
    reg [3:0]  irq_stat_reg;
    reg [3:0]  irq_mask_reg;

    reg        aw_hold_reg;
    reg [11:0] aw_addr_reg;
    reg        w_hold_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `SFCC_ADDR_FTN) || (a == `SFCC_ADDR_CF) ||
                        (a == `SFCC_ADDR_DCU) || (a == `SFCC_ADDR_TST) ||
                        (a == `SFCC_ADDR_IRQ_STAT) ||
                        (a == `SFCC_ADDR_IRQ_MASK) ||
                        (a == `SFCC_ADDR_CTRL);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;

    wire aw_have = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
    wire w_have  = w_hold_reg | (s_axi_wvalid & s_axi_wready);
    wire [11:0] wa = aw_hold_reg ? aw_addr_reg :
                     {s_axi_awaddr[11:2], 2'b00};
    wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]  ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
    wire        wr_fire = aw_have & w_have & ~bvalid_reg;
    wire        wr_b0   = wr_fire & ws[0];

    wire        wr_ftn  = wr_b0 & (wa == `SFCC_ADDR_FTN);
    wire        wr_cf   = wr_b0 & (wa == `SFCC_ADDR_CF);
    wire        wr_dcu  = wr_b0 & (wa == `SFCC_ADDR_DCU);

    wire cf_start  = wr_cf & wd[`SFCC_BIT_GO] & ~cf_go_reg;
    wire dcu_start = wr_dcu & wd[`SFCC_BIT_GO] & ~dcu_go_reg;
    wire filter_tune_go = (wr_ftn & wd[`SFCC_BIT_GO] & ~ftn_go_reg) |
                     (idle_entry & ~ftn_go_reg);

    //////////////////////////////////////////////////////////////////////////
    // Calibration timers, independent so they overlap freely
    wire cf_busy;
    wire cf_done;
    wire dcu_busy;
    wire dcu_done;
    wire ftn_busy;
    wire ftn_done;

    sfcc_cal_timer #(.CYCLES(`SFCC_CYC_CF), .CW(CW)) u_cf_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (cf_start),
        .busy_o    (cf_busy),
        .done_o    (cf_done)
    );

    sfcc_cal_timer #(.CYCLES(`SFCC_CYC_DCU), .CW(CW)) u_dcu_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (dcu_start),
        .busy_o    (dcu_busy),
        .done_o    (dcu_done)
    );

    sfcc_cal_timer #(.CYCLES(`SFCC_CYC_FTN), .CW(CW)) u_ftn_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (filter_tune_go),
        .busy_o    (ftn_busy),
        .done_o    (ftn_done)
    );

    // No state gating on starts: calibration proceeds in any radio state
    assign cal_running_o = cf_busy | dcu_busy | ftn_busy;

    //////////////////////////////////////////////////////////////////////////
    // Interrupt events
    reg [3:0] irq_evt;
    always @* begin
        irq_evt = 4'h0;
        irq_evt[`SFCC_IRQ_LOCK]     = cf_done;
        irq_evt[`SFCC_IRQ_UNLOCK]   = cf_start & synth_on;
        irq_evt[`SFCC_IRQ_FTN_DONE] = ftn_done;
        irq_evt[`SFCC_IRQ_DCU_DONE] = dcu_done;
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    //////////////////////////////////////////////////////////////////////////
    // Register state
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ftn_go_reg    <= 1'b0;
            ftn_rsvd_reg  <= 1'b1;
            ftn_value_reg <= `SFCC_RST_FTN_VALUE;
            cf_go_reg     <= 1'b0;
            cf_low_reg    <= `SFCC_RST_CF_LOW;
            dcu_go_reg    <= 1'b0;
            dcu_low_reg   <= `SFCC_RST_DCU_LOW;
            tst_reg       <= `SFCC_RST_TST;
            irq_stat_reg  <= 4'h0;
            irq_mask_reg  <= 4'h0;
        end else begin
            if (cf_start)
                cf_go_reg <= 1'b1;
            else if (cf_done)
                cf_go_reg <= 1'b0;
            if (dcu_start)
                dcu_go_reg <= 1'b1;
            else if (dcu_done)
                dcu_go_reg <= 1'b0;
            if (filter_tune_go)
                ftn_go_reg <= 1'b1;
            else if (ftn_done)
                ftn_go_reg <= 1'b0;
            if (wr_ftn) begin
                ftn_rsvd_reg  <= wd[6];
                ftn_value_reg <= wd[5:0];
            end
            if (wr_cf)
                cf_low_reg <= wd[6:0];
            if (wr_dcu)
                dcu_low_reg <= {1'b0, wd[5:0]};
            if (wr_b0 & (wa == `SFCC_ADDR_TST))
                tst_reg <= wd[7:0];
            if (wr_b0 & (wa == `SFCC_ADDR_IRQ_MASK))
                irq_mask_reg <= wd[3:0];
            // A new event wins over a write-one clear in the same cycle
            if (wr_b0 & (wa == `SFCC_ADDR_IRQ_STAT))
                irq_stat_reg <= (irq_stat_reg & ~wd[3:0]) | irq_evt;
            else
                irq_stat_reg <= irq_stat_reg | irq_evt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Override outputs: stored TST values apply only with the monitor enabled, the tune value always
    wire [7:0] tst_eff = power_mon_en ? tst_reg : `SFCC_RST_TST;
    reg        chip_reg;
    reg        dir_reg;

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_reg <= 1'b0;
            dir_reg  <= 1'b0;
        end else begin
            chip_reg <= tst_eff[`SFCC_BIT_CHIP_SEL] ?
                        tst_eff[`SFCC_BIT_CHIP_VAL] : normal_chip_i;
            dir_reg  <= tst_eff[`SFCC_BIT_DIR_SEL] ?
                        tst_eff[`SFCC_BIT_DIR] : normal_tx_dir_i;
        end
    end

    assign modulator_chip_o    = chip_reg;
    assign synth_tx_dir_o      = dir_reg;
    assign filter_tune_value_o = ftn_value_reg;

    //////////////////////////////////////////////////////////////////////////
    // Bus handshakes and read path
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
        end else begin
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= is_mapped(wa) ? 2'h0 : 2'h2;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_hold_reg <= 1'b1;
                    aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_hold_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (bvalid_reg & s_axi_bready)
                    bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_arready = ~rvalid_reg;
    wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
    reg  [7:0]  rd_byte;

    always @* begin
        case (ra)
            `SFCC_ADDR_FTN:      rd_byte = {ftn_go_reg, ftn_rsvd_reg,
                                            ftn_value_reg};
            `SFCC_ADDR_CF:       rd_byte = {cf_go_reg, cf_low_reg};
            `SFCC_ADDR_DCU:      rd_byte = {dcu_go_reg, dcu_low_reg};
            `SFCC_ADDR_TST:      rd_byte = tst_reg;
            `SFCC_ADDR_IRQ_STAT: rd_byte = {4'h0, irq_stat_reg};
            `SFCC_ADDR_IRQ_MASK: rd_byte = {4'h0, irq_mask_reg};
            `SFCC_ADDR_CTRL:     rd_byte = {5'h00, synth_on, power_mon_en,
                                            cal_running_o};
            default:             rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= 2'h0;
        end else if (s_axi_arvalid & s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= is_mapped(ra) ? 2'h0 : 2'h2;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
endmodule

// ---- rtl/sfcc_consts.vh ----
// Register map, field positions, reset values and timing for the calibration controller
`ifndef SFCC_CONSTS_VH
`define SFCC_CONSTS_VH

`define SFCC_IDX_FTN        8'h18
`define SFCC_IDX_CF         8'h1a
`define SFCC_IDX_DCU        8'h1b
`define SFCC_IDX_TST        8'h3d
`define SFCC_ADDR_FTN       12'h060
`define SFCC_ADDR_CF        12'h068
`define SFCC_ADDR_DCU       12'h06c
`define SFCC_ADDR_TST       12'h0f4
`define SFCC_ADDR_IRQ_STAT  12'h100
`define SFCC_ADDR_IRQ_MASK  12'h104
`define SFCC_ADDR_CTRL      12'h108

`define SFCC_BIT_GO         7
`define SFCC_BIT_CHIP_SEL   7
`define SFCC_BIT_CHIP_VAL   6
`define SFCC_BIT_DIR        5
`define SFCC_BIT_DIR_SEL    4

`define SFCC_RST_FTN_VALUE  6'h18
`define SFCC_RST_CF_LOW     7'h57
`define SFCC_RST_DCU_LOW    7'h20
`define SFCC_RST_TST        8'h00

`define SFCC_IRQ_LOCK       0
`define SFCC_IRQ_UNLOCK     1
`define SFCC_IRQ_FTN_DONE   2
`define SFCC_IRQ_DCU_DONE   3

`define SFCC_CLK_MHZ        25
`define SFCC_T_CF_US        8
`define SFCC_T_DCU_US       6
`define SFCC_T_FTN_US       25
`define SFCC_CYC_CF         (`SFCC_T_CF_US * `SFCC_CLK_MHZ)
`define SFCC_CYC_DCU        (`SFCC_T_DCU_US * `SFCC_CLK_MHZ)
`define SFCC_CYC_FTN        (`SFCC_T_FTN_US * `SFCC_CLK_MHZ)

`endif

// ---- rtl/sfcc_cal_timer.v ----
// Single calibration timer: busy from start until a fixed cycle count expires
`timescale 1ns/1ps
module sfcc_cal_timer #(
    parameter CYCLES = 200,
    parameter CW     = 10
) (
    input  wire clk_sys_i,
    input  wire rst_n_i,
    input  wire start_i,
    output wire busy_o,
    output wire done_o
);
    reg [CW-1:0] cnt_reg;
    reg          busy_reg;
    reg          done_reg;

    // A start while busy is ignored so a running cycle always completes
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= {CW{1'b0}};
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg) begin
                if (start_i) begin
                    busy_reg <= 1'b1;
                    cnt_reg  <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
                end
            end else if (cnt_reg == {CW{1'b0}}) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule

// ---- testbench/sfcc_calib_ctrl_asserts.sv ----
// Checker of bus handshakes, override paths and calibration timing
`timescale 1ns/1ps
module sfcc_calib_ctrl_asserts (
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        power_monitor_enable_i,
    input wire        normal_chip_i,
    input wire        normal_tx_dir_i,
    input wire        modulator_chip_o,
    input wire        synth_tx_dir_o,
    input wire [5:0]  filter_tune_value_o,
    input wire        cal_running_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);
//////////////////////////////////////////////////////////////////////////////
sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
// Idle timers first, so the busy window is the fresh start's own
sequence cf_go;
    wr_taken ##0 (s_axi_awaddr == 12'h068 && s_axi_wstrb[0]
                  && s_axi_wdata[7] && !cal_running_o);
endsequence
write_ok_a: assert property (wr_taken ##0 (s_axi_awaddr == 12'h068)
    |=> s_axi_bvalid && s_axi_bresp == 2'b00) else $error("write resp bad");
write_err_a: assert property (wr_taken ##0 (s_axi_awaddr == 12'h200)
    |=> s_axi_bvalid && s_axi_bresp == 2'b10) else $error("no slave error");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid dropped");
read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
write_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
cf_busy_a: assert property (cf_go |=> cal_running_o [*8])
    else $error("calibration not running");
chip_normal_a: assert property ((!power_monitor_enable_i) [*4]
    |-> modulator_chip_o == $past(normal_chip_i)) else $error("chip override");
dir_normal_a: assert property ((!power_monitor_enable_i) [*4]
    |-> synth_tx_dir_o == $past(normal_tx_dir_i)) else $error("dir override");
tune_reset_a: assert property ($rose(rst_n_i)
    |-> filter_tune_value_o == 6'h18) else $error("tune value reset");
endmodule
bind sfcc_calib_ctrl sfcc_calib_ctrl_asserts u_sfcc_chk (.*);

// ---- testbench/test_synth_filter_calibration_ctrl.sv ----
// Self-checking bench of the calibration and override register bank
`timescale 1ns/1ps
`include "sfcc_consts.vh"
module test_synth_filter_calibration_ctrl;
reg         clk_sys_i = 0, rst_n_i = 0;
reg  [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
reg  [31:0] s_axi_wdata = 0;
reg  [3:0]  s_axi_wstrb = 4'h1;
reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
reg         s_axi_arvalid = 0, s_axi_rready = 0, synth_active_i = 0;
reg         power_monitor_enable_i = 0, radio_idle_entry_i = 0;
reg         normal_chip_i = 0, normal_tx_dir_i = 0;
wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire        s_axi_rvalid, modulator_chip_o, synth_tx_dir_o;
wire        cal_running_o, irq_o;
wire [1:0]  s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [5:0]  filter_tune_value_o;
integer     n_errors = 0, check_count = 0, cyc = 0, k, t0, n;
reg  [31:0] lfsr = 32'he433d22f, rd, d, st;
reg  [11:0] a;
reg  [7:0]  ftn;
reg  [1:0]  resp;
sfcc_calib_ctrl dut (.*);
always #20 clk_sys_i = ~clk_sys_i;
// Ceiling well above the few thousand cycles the tests need
always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
        n_errors = n_errors + 1;
        final_report;
    end
end
//////////////////////////////////////////////////////////////////////////////
function [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task chk_word(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
        check_count = check_count + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s exp %h got %h", nm, e, g);
        end
    end
endtask
task chk_bit(input [8*6:1] nm, input e, input g);
    begin
        check_count = check_count + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s exp %b got %b", nm, e, g);
        end
    end
endtask
// Handshakes are judged at the negedge, where readies have settled
task axi_wr(input [11:0] wa, input [31:0] wd);
    reg a_ok, w_ok, b_ok;
    begin
        @(posedge clk_sys_i);
        s_axi_awaddr <= wa;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        a_ok = 0;
        w_ok = 0;
        b_ok = 0;
        while (!b_ok) begin
            @(negedge clk_sys_i);
            a_ok = a_ok | (s_axi_awvalid & s_axi_awready);
            w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
            b_ok = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys_i);
            if (a_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    end
endtask
task rd_chk(input [11:0] ra, input [31:0] e, input [1:0] er);
    reg a_ok, r_ok;
    begin
        @(posedge clk_sys_i);
        s_axi_araddr <= ra;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        a_ok = 0;
        r_ok = 0;
        while (!r_ok) begin
            @(negedge clk_sys_i);
            a_ok = a_ok | (s_axi_arvalid & s_axi_arready);
            r_ok = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys_i);
            if (a_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk_word("rdata", e, rd);
        chk_word("rresp", er, {30'h0, resp});
    end
endtask
task wait_idle;
    while (cal_running_o !== 1'b0) @(negedge clk_sys_i);
endtask
task final_report;
    begin
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end
endtask
//////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_chk(`SFCC_ADDR_FTN, 32'h58, 2'h0);
    rd_chk(`SFCC_ADDR_CF, 32'h57, 2'h0);
    rd_chk(`SFCC_ADDR_DCU, 32'h20, 2'h0);
    rd_chk(`SFCC_ADDR_TST, 32'h0, 2'h0);
    rd_chk(12'h200, 32'h0, 2'h2);
    axi_wr(12'h200, 32'hff);
    chk_word("bresp", 32'h2, {30'h0, resp});
    $display("reset values done");
    for (k = 0; k < 4; k = k + 1) begin
        lfsr = rnd(lfsr);
        ftn = (k == 0) ? 8'h00 : (k == 1) ? 8'h3f : {1'b0, lfsr[6:0]};
        axi_wr(`SFCC_ADDR_FTN, {24'h0, ftn});
        chk_word("bresp", 32'h0, {30'h0, resp});
        rd_chk(`SFCC_ADDR_FTN, {24'h0, ftn}, 2'h0);
        chk_word("ftv", ftn[5:0], filter_tune_value_o);
    end
    $display("tune value done");
    for (k = 0; k < 32; k = k + 1) begin
        lfsr = rnd(lfsr);
        d = {24'h0, k[3:0], lfsr[5:2]};
        @(posedge clk_sys_i);
        power_monitor_enable_i <= k[4];
        normal_chip_i <= lfsr[0];
        normal_tx_dir_i <= lfsr[1];
        axi_wr(`SFCC_ADDR_TST, d);
        repeat (4) @(negedge clk_sys_i);
        chk_bit("chip", k[4] & k[3] ? k[2] : lfsr[0],
                modulator_chip_o);
        chk_bit("dir", k[4] & k[0] ? k[1] : lfsr[1], synth_tx_dir_o);
        rd_chk(`SFCC_ADDR_TST, d, 2'h0);
    end
    $display("overrides done");
    axi_wr(`SFCC_ADDR_IRQ_STAT, 32'hf);
    synth_active_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    st = 0;
    for (k = 0; k < 3; k = k + 1) begin
        a = k == 0 ? `SFCC_ADDR_CF : k == 1 ? `SFCC_ADDR_DCU : `SFCC_ADDR_FTN;
        d = k == 0 ? 32'h57 : k == 1 ? 32'h20 : {24'h0, ftn};
        n = k == 0 ? 8 * 25 : k == 1 ? 6 * 25 : 25 * 25;
        st = st | (k == 0 ? 32'h3 : k == 1 ? 32'h8 : 32'h4);
        axi_wr(a, d | 32'h80);
        t0 = cyc;
        rd_chk(a, d | 32'h80, 2'h0);
        wait_idle;
        chk_bit("length", 1'b1, cyc - t0 >= n - 1 && cyc - t0 <= n + 3);
        rd_chk(a, d, 2'h0);
        rd_chk(`SFCC_ADDR_IRQ_STAT, st, 2'h0);
    end
    $display("calibrations done");
    chk_bit("irq", 1'b0, irq_o);
    axi_wr(`SFCC_ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(negedge clk_sys_i);
    chk_bit("irq", 1'b1, irq_o);
    axi_wr(`SFCC_ADDR_IRQ_STAT, 32'h4);
    repeat (2) @(negedge clk_sys_i);
    chk_bit("irq", 1'b0, irq_o);
    rd_chk(`SFCC_ADDR_IRQ_STAT, 32'hb, 2'h0);
    $display("interrupts done");
    // Synth off and status cleared, so a start here must not flag unlock
    synth_active_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    axi_wr(`SFCC_ADDR_IRQ_STAT, 32'hf);
    axi_wr(`SFCC_ADDR_CF, 32'hd7);
    axi_wr(`SFCC_ADDR_DCU, 32'ha0);
    // Past the delay-cell run but well inside the centre run
    repeat (160) @(posedge clk_sys_i);
    rd_chk(`SFCC_ADDR_DCU, 32'h20, 2'h0);
    rd_chk(`SFCC_ADDR_CF, 32'hd7, 2'h0);
    wait_idle;
    rd_chk(`SFCC_ADDR_CF, 32'h57, 2'h0);
    $display("concurrent done");
    @(posedge clk_sys_i);
    radio_idle_entry_i <= 1'b1;
    repeat (5) @(negedge clk_sys_i);
    chk_bit("auto", 1'b1, cal_running_o);
    rd_chk(`SFCC_ADDR_FTN, {24'h0, ftn} | 32'h80, 2'h0);
    wait_idle;
    rd_chk(`SFCC_ADDR_IRQ_STAT, 32'hd, 2'h0);
    chk_bit("irq", 1'b1, irq_o);
    $display("auto tune done");
    final_report;
end
endmodule
